// ===== core/sleep_ctrl.sv
// Sleep mode controller: clock gating per domain, reset control and port tri-state
// Assumes the core requests sleep with a pulse and waits for cpu_clk_en_o on wake
//
// Behaviour
// - Idle stops only the processor clock; memory, timers, serial and interrupts run.
// - Power-down keeps state, stops oscillator and all functions until interrupt or reset.
// - Power-save keeps the asynchronous timer clocked.
// - Converter noise reduction runs only the asynchronous timer, the converter and the main oscillator.
// - Standby keeps the main oscillator running, everything else asleep.
// - Extended standby keeps main oscillator and asynchronous timer running.
// - Six software-selectable sleep modes are offered.
// - External reset low longer than minimum length resets; the filter counts on clk_i, so a clock is needed.
// - Any active reset tri-states every port pin; power-on and internal reset do so even without clock, the pin reset only once filtered.
// - Four 8-bit bidirectional ports with per-bit pull-up enables.
`timescale 1ns/100ps
`include "sleep_ctrl_params.svh"
module sleep_ctrl
  import sleep_ctrl_pkg::*;
#(
  parameter int PORT_N = `PORT_N,
  parameter int PORT_W = `PORT_W,
  parameter int SETTLE = `WAKE_SETTLE_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Reset pin and other reset sources
  input wire logic ext_rst_n_i,
  input wire logic int_rst_i,
  output logic sys_rst_o,
  // Sleep request from the core
  input wire logic sleep_req_i,
  input wire logic [2:0] sleep_mode_i,
  input wire logic wake_irq_i,
  output logic sleeping_o,
  // Domain clock enables
  output logic cpu_clk_en_o,
  output logic io_clk_en_o,
  output logic async_clk_en_o,
  output logic adc_clk_en_o,
  output logic osc_en_o,
  // Port control from core
  input wire logic [PORT_N*PORT_W-1:0] port_out_i,
  input wire logic [PORT_N*PORT_W-1:0] port_dir_i,
  input wire logic [PORT_N*PORT_W-1:0] port_pu_i,
  // Port pins
  input wire logic [PORT_N*PORT_W-1:0] pin_i,
  output logic [PORT_N*PORT_W-1:0] pin_o,
  output logic [PORT_N*PORT_W-1:0] pin_oe_o,
  output logic [PORT_N*PORT_W-1:0] pin_pu_o,
  output logic [PORT_N*PORT_W-1:0] pin_in_o
);
  logic rst_s1_r;
  logic rst_s2_r;
  logic ext_rst;
  logic any_rst_async;
  pwr_state_t state_r;
  sleep_mode_t mode_r;
  logic [7:0] settle_r;
  logic [4:0] dom_r;

  // Reset release through two flops
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end

  reset_filter u_filt (
    .clk_i(clk_i),
    .rst_n_i(rst_s2_r),
    .ext_rst_n_i(ext_rst_n_i),
    .ext_rst_o(ext_rst)
  );

  // Reset gates the tri-state combinationally; the pin path goes through the clocked filter first
  assign any_rst_async = !rst_n_i || !rst_s2_r || ext_rst || int_rst_i;
  assign sys_rst_o = any_rst_async;

  // Domain enable vector: cpu, io, async, adc, osc
  function automatic logic [4:0] domains(input sleep_mode_t m);
    logic [4:0] d;
    d = 5'h00;
    unique case (m)
      MODE_IDLE: d = 5'h0F;
      MODE_ADC_NR: d = 5'h07;
      MODE_PWR_DOWN: d = 5'h00;
      MODE_PWR_SAVE: d = 5'h04;
      MODE_STANDBY: d = 5'h01;
      MODE_EXT_STANDBY: d = 5'h05;
      default: d = 5'h1E;
    endcase
    return d;
  endfunction : domains

  function automatic logic mode_legal(input logic [2:0] m);
    return (m != 3'h4) && (m != 3'h5);
  endfunction : mode_legal

  // Sleep state machine
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= ST_RUN;
      mode_r <= MODE_IDLE;
      settle_r <= 8'h00;
    end else if (any_rst_async) begin
      state_r <= ST_RUN;
      settle_r <= 8'h00;
    end else begin
      unique case (state_r)
        ST_RUN: begin
          if (sleep_req_i && mode_legal(sleep_mode_i)) begin
            mode_r <= sleep_mode_t'(sleep_mode_i);
            state_r <= ST_SLEEP;
          end
        end
        ST_SLEEP: begin
          if (wake_irq_i) begin
            state_r <= ST_WAKE;
            settle_r <= 8'h00;
          end
        end
        ST_WAKE: begin
          if (settle_r >= 8'(SETTLE)) begin
            state_r <= ST_RUN;
          end else begin
            settle_r <= settle_r + 8'h01;
          end
        end
        default: state_r <= ST_RUN;
      endcase
    end
  end

  // Domain enables: all but cpu back on in the wake phase, cpu last, one cycle after return to run
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dom_r <= 5'h1F;
    end else if (any_rst_async) begin
      dom_r <= 5'h1F;
    end else if (state_r == ST_SLEEP && !wake_irq_i) begin
      dom_r <= domains(mode_r);
    end else if (state_r == ST_WAKE || (state_r == ST_SLEEP && wake_irq_i)) begin
      dom_r <= 5'h0F;
    end else if (state_r == ST_RUN && sleep_req_i && mode_legal(sleep_mode_i)) begin
      dom_r <= domains(sleep_mode_t'(sleep_mode_i));
    end else begin
      dom_r <= 5'h1F;
    end
  end

  assign cpu_clk_en_o = dom_r[4];
  assign io_clk_en_o = dom_r[3];
  assign async_clk_en_o = dom_r[2];
  assign adc_clk_en_o = dom_r[1];
  assign osc_en_o = dom_r[0];
  assign sleeping_o = (state_r != ST_RUN);

  // Port pins, tri-stated with pull-ups off during any reset
  genvar g;
  generate
    for (g = 0; g < PORT_N; g++) begin : g_port
      logic [PORT_W-1:0] out_r;
      always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          out_r <= '0;
        end else begin
          out_r <= port_out_i[g*PORT_W +: PORT_W];
        end
      end
      assign pin_o[g*PORT_W +: PORT_W] = out_r;
      assign pin_oe_o[g*PORT_W +: PORT_W] =
        any_rst_async ? '0 : port_dir_i[g*PORT_W +: PORT_W];
      assign pin_pu_o[g*PORT_W +: PORT_W] = any_rst_async ? '0 :
        (port_pu_i[g*PORT_W +: PORT_W] & ~port_dir_i[g*PORT_W +: PORT_W]);
      assign pin_in_o[g*PORT_W +: PORT_W] = pin_i[g*PORT_W +: PORT_W];
    end
  endgenerate
endmodule : sleep_ctrl

// ===== core/sleep_ctrl_params.svh
// Constants of the sleep and clock gating controller
// Assumes inclusion by bare name from the core files
`ifndef SLEEP_CTRL_PARAMS_SVH
`define SLEEP_CTRL_PARAMS_SVH
`define MODE_W 3
`define PORT_W 8
`define PORT_N 4
`define RST_FILT_NS 2500
`define CLK_NS 25
`define RST_FILT_CYC ((`RST_FILT_NS + `CLK_NS - 1) / `CLK_NS)
`define WAKE_SETTLE_CYC 4
`endif

// ===== core/sleep_ctrl_pkg.sv
// Types of the sleep and clock gating controller
// Assumes the params header is compiled alongside
package sleep_ctrl_pkg;
  typedef enum logic [2:0] {
    MODE_IDLE = 3'h0,
    MODE_ADC_NR = 3'h1,
    MODE_PWR_DOWN = 3'h2,
    MODE_PWR_SAVE = 3'h3,
    MODE_STANDBY = 3'h6,
    MODE_EXT_STANDBY = 3'h7
  } sleep_mode_t;
  typedef enum logic [1:0] {
    ST_RUN = 2'h0,
    ST_SLEEP = 2'h1,
    ST_WAKE = 2'h2
  } pwr_state_t;
endpackage : sleep_ctrl_pkg

// ===== core/reset_filter.sv
// Glitch filter on the external reset pin, counted on the system clock
// Assumes the pin is synchronous to clk_i; a low shorter than the count is ignored
`timescale 1ns/100ps
`include "sleep_ctrl_params.svh"
module reset_filter #(
  parameter int CYC = `RST_FILT_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Pin and result
  input wire logic ext_rst_n_i,
  output logic ext_rst_o
);
  logic [15:0] cnt_r;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= 16'h0000;
    end else if (ext_rst_n_i) begin
      cnt_r <= 16'h0000;
    end else if (cnt_r < 16'(CYC)) begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end
  assign ext_rst_o = (cnt_r >= 16'(CYC));
endmodule : reset_filter

// ===== tb/sleep_ctrl_monitor.sv
// Assertions on the ports of the sleep controller
// Assumes it is bound into sleep_ctrl with the same port widths
`timescale 1ns/100ps
module sleep_ctrl_monitor
  import sleep_ctrl_pkg::*;
#(
  parameter int PORT_N = 4,
  parameter int PORT_W = 8
) (
  // Inputs of the block
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ext_rst_n_i,
  input wire logic sleep_req_i,
  input wire logic [2:0] sleep_mode_i,
  // Outputs of the block
  input wire logic sys_rst_o,
  input wire logic sleeping_o,
  input wire logic cpu_clk_en_o,
  input wire logic io_clk_en_o,
  input wire logic async_clk_en_o,
  input wire logic adc_clk_en_o,
  input wire logic osc_en_o,
  input wire logic [PORT_N*PORT_W-1:0] pin_oe_o,
  input wire logic [PORT_N*PORT_W-1:0] pin_pu_o
);
  logic [7:0] low_cnt_r;
  logic take;
  logic [4:0] en;
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  assign take = sleep_req_i && !sleeping_o && !sys_rst_o;
  assign en = {cpu_clk_en_o, io_clk_en_o, async_clk_en_o, adc_clk_en_o, osc_en_o};
  // Length of the current low on the reset pin, saturating
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      low_cnt_r <= 8'h00;
    end else if (ext_rst_n_i) begin
      low_cnt_r <= 8'h00;
    end else if (low_cnt_r != 8'hFF) begin
      low_cnt_r <= low_cnt_r + 8'h01;
    end
  end
  chk_idle_enables: assert property (take && sleep_mode_i == MODE_IDLE |=> en == 5'h0F)
    else $error("idle enables wrong");
  chk_pdown_enables: assert property (take && sleep_mode_i == MODE_PWR_DOWN |=> en == 5'h00)
    else $error("power-down enables wrong");
  chk_psave_enables: assert property (take && sleep_mode_i == MODE_PWR_SAVE |=> en == 5'h04)
    else $error("power-save enables wrong");
  chk_adcnr_enables: assert property (take && sleep_mode_i == MODE_ADC_NR |=> en == 5'h07)
    else $error("noise reduction enables wrong");
  chk_stby_enables: assert property (take && sleep_mode_i == MODE_STANDBY |=> en == 5'h01)
    else $error("standby enables wrong");
  chk_xstby_enables: assert property (take && sleep_mode_i == MODE_EXT_STANDBY |=> en == 5'h05)
    else $error("extended standby enables wrong");
  chk_pin_reset_long: assert property (low_cnt_r >= 8'h68 |-> sys_rst_o)
    else $error("long pin low gave no reset");
  chk_reset_tristate: assert property (sys_rst_o |-> pin_oe_o == '0 && pin_pu_o == '0)
    else $error("port driven in reset");
  chk_wake_order: assert property ($rose(cpu_clk_en_o) && !$past(sys_rst_o) |->
    &en[3:0] && $past(&en[3:0]))
    else $error("processor clock before domains");
  chk_pullup_inputs: assert property ((pin_pu_o & pin_oe_o) == '0)
    else $error("pull-up on a driven pin");
  cover property (take && sleep_mode_i == MODE_PWR_DOWN);
  cover property ($rose(cpu_clk_en_o));
  cover property ($rose(sys_rst_o) && !ext_rst_n_i);
endmodule : sleep_ctrl_monitor
bind sleep_ctrl sleep_ctrl_monitor #(.PORT_N(PORT_N), .PORT_W(PORT_W)) u_mon (.clk_i, .rst_n_i,
  .ext_rst_n_i, .sleep_req_i, .sleep_mode_i, .sys_rst_o, .sleeping_o, .cpu_clk_en_o, .io_clk_en_o,
  .async_clk_en_o, .adc_clk_en_o, .osc_en_o, .pin_oe_o, .pin_pu_o);

// ===== tb/tb.sv
// Self-checking bench of the sleep controller
// Assumes the core files and the monitor are compiled before it
`timescale 1ns/100ps
module tb;
  import sleep_ctrl_pkg::*;
  logic clk_i = 0, rst_n_i = 0, ext_rst_n_i = 1, int_rst_i = 0, sleep_req_i = 0, wake_irq_i = 0;
  logic [2:0] sleep_mode_i = 3'h0;
  logic [31:0] port_out_i = 32'hA5C3_0F96, port_dir_i = 32'hFF00_F0C3;
  logic [31:0] port_pu_i = 32'h0FF0_3C5A, pin_i = 32'h1234_ABCD;
  logic [31:0] pin_o, pin_oe_o, pin_pu_o, pin_in_o;
  logic sys_rst_o, sleeping_o, cpu_clk_en_o, io_clk_en_o, async_clk_en_o, adc_clk_en_o, osc_en_o;
  logic [4:0] en;
  int n_errors = 0, n_tests = 0;
  assign en = {cpu_clk_en_o, io_clk_en_o, async_clk_en_o, adc_clk_en_o, osc_en_o};
  always #12.5 clk_i = ~clk_i;
  sleep_ctrl u_dut (.clk_i, .rst_n_i, .ext_rst_n_i, .int_rst_i, .sys_rst_o, .sleep_req_i,
    .sleep_mode_i, .wake_irq_i, .sleeping_o, .cpu_clk_en_o, .io_clk_en_o, .async_clk_en_o,
    .adc_clk_en_o, .osc_en_o, .port_out_i, .port_dir_i, .port_pu_i, .pin_i, .pin_o, .pin_oe_o,
    .pin_pu_o, .pin_in_o);
  task automatic chk(string n, logic [32:0] e, logic [32:0] s);
    n_tests++;
    if (e !== s) begin
      n_errors++;
      $display("[FAIL] %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task automatic cyc(int n);
    repeat (n) @(negedge clk_i);
  endtask : cyc
  task automatic sleep_wake(logic [2:0] m, logic [4:0] e);
    sleep_req_i = 1;
    sleep_mode_i = m;
    cyc(1);
    sleep_req_i = 0;
    cyc(1);
    chk("enables", e, en);
    cyc(10);
    chk("asleep", 1'h1, sleeping_o);
    wake_irq_i = 1;
    cyc(1);
    wake_irq_i = 0;
    for (int i = 0; i < 20 && cpu_clk_en_o !== 1'h1; i++) cyc(1);
    chk("woken", 6'h1F, {sleeping_o, en});
    cyc(1);
  endtask : sleep_wake
  task automatic refused;
    for (int m = 4; m < 6; m++) begin
      sleep_req_i = 1;
      sleep_mode_i = 3'(m);
      cyc(1);
      sleep_req_i = 0;
      cyc(2);
      chk("refused", 6'h1F, {sleeping_o, en});
    end
  endtask : refused
  task automatic ports;
    cyc(2);
    chk("oe", port_dir_i, pin_oe_o);
    chk("pu", port_pu_i & ~port_dir_i, pin_pu_o);
    chk("in", pin_i, pin_in_o);
    chk("out", port_out_i, pin_o);
    int_rst_i = 1;
    cyc(1);
    chk("int tri", 33'h1_0000_0000, {sys_rst_o, pin_oe_o | pin_pu_o});
    int_rst_i = 0;
    cyc(3);
  endtask : ports
  task automatic pin_reset;
    ext_rst_n_i = 0;
    cyc(50);
    chk("short", 1'h0, sys_rst_o);
    cyc(60);
    chk("long", 33'h1_0000_0000, {sys_rst_o, pin_oe_o | pin_pu_o});
    ext_rst_n_i = 1;
    cyc(3);
    chk("release", 1'h0, sys_rst_o);
  endtask : pin_reset
  task automatic print_verdict;
    if (n_errors == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : print_verdict
  initial begin
    cyc(5);
    rst_n_i = 1;
    cyc(3);
    ports();
    sleep_wake(MODE_IDLE, 5'h0F);
    sleep_wake(MODE_PWR_DOWN, 5'h00);
    sleep_wake(MODE_PWR_SAVE, 5'h04);
    sleep_wake(MODE_ADC_NR, 5'h07);
    sleep_wake(MODE_STANDBY, 5'h01);
    sleep_wake(MODE_EXT_STANDBY, 5'h05);
    refused();
    pin_reset();
    print_verdict();
  end
  initial begin
    #50us;
    n_errors++;
    print_verdict();
  end
endmodule : tb
